// ---- rtl/smwc_top.v ----
// Mode select, main status and watchdog supervisor of the basis chip
//
// Function
// - Mode field codes: 001 Sleep, 100 Standby, 111 Normal.
// - Status bit 6 follows the temperature warning level.
// - Status bit 5 reads 1 until Normal first entered, then 0.
// - Reset cause 00000 power-on, 10001 external pin, 10011 undervoltage.
// - Wake resets: 00001 bus, 00100 local input, 01101 diagnostic.
// - 10010 overtemp exit, 10100 illegal sleep, 10110 frame error wake.
// - Watchdog causes 01100 sleep overflow, 01110 early, 01111 overflow.
// - Window, Timeout, Autonomous; window only acts in Normal mode.
// - Timeout mode runs continuously; any trigger restarts it.
// - Mode change in Standby; Window acts as Timeout until Normal.
// - Changing supervisor mode in Normal forces reset, cause 10000.
// - Period field selects one of eight nominal periods.
// - Defaults: period 128 ms, mode Timeout.
// - Valid control write triggers; new mode and period apply at once unless it changes mode in Normal.
// - Without dev bit, Autonomous runs Timeout in Normal or Standby with wake pending.
// - Window/Timeout run Timeout in Standby and Sleep, Timeout also in Normal; off outside these.
// - Mode codes 001, 010, 100; Autonomous default when dev bit set.
// - Invalid mode or period code abandons the write, flags failure.
// - Valid codes differ in at least two bit positions.
// - Watchdog off in Forced Normal mode.
// - Window: early trigger or overflow resets; late trigger restarts.
// - Timeout overflow sets failure flag; second resets; sleep wakes.
`timescale 1ns/1ps
`default_nettype none
`include "smwc_defines.vh"

module smwc_top (
  input wire clk_i,
  input wire nrst_i,
  input wire wr_i,
  input wire rd_i,
  input wire [6:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  output reg spi_fail_o,
  input wire spi_fail_en_i,
  input wire [7:0] chip_state_i,
  input wire wake_pending_i,
  input wire forced_normal_config_bit_i,
  input wire software_dev_config_bit_i,
  input wire temp_warning_i,
  input wire [4:0] ext_reset_cause_i,
  input wire ext_reset_i,
  input wire wdf_clear_i,
  output reg [2:0] chip_mode_field_o,
  output reg wd_reset_req_o,
  output reg wd_wake_o,
  output reg supervisor_failure_flag_o,
  output reg [1:0] wd_phase_o
);

  // chip_state_i is one-hot: the chip-level mode sequencer owns it
  localparam ST_NORMAL = 0;
  localparam ST_STANDBY = 1;
  localparam ST_SLEEP = 2;
  localparam ST_FORCED = 3;

  // Supervisor behaviour states, one-hot
  localparam WS_OFF = 3'b001;
  localparam WS_TIMEOUT = 3'b010;
  localparam WS_WINDOW = 3'b100;

  // ================================================================
  // Register state
  reg [2:0] supervisor_mode_field_reg;
  reg [3:0] supervisor_period_field_reg;
  reg first_normal_entry_flag_reg;
  reg [4:0] reset_cause_field_reg;
  // 30 bits hold the longest period of 4096 ms
  reg [29:0] wd_cnt_reg;
  reg strap_done_reg;
  reg [2:0] wd_state;
  reg [29:0] period_cycles;
  reg mode_ok;
  reg period_ok;
  reg wd_write;
  reg trig_valid;
  reg ill_wmc;
  reg overflow;

  wire in_normal = chip_state_i[ST_NORMAL];
  wire in_standby = chip_state_i[ST_STANDBY];
  wire in_sleep = chip_state_i[ST_SLEEP];
  wire in_forced = chip_state_i[ST_FORCED];
  wire [2:0] new_mode = wdata_i[`SMWC_WM_HI:`SMWC_WM_LO];
  wire [3:0] new_period = wdata_i[`SMWC_NWP_HI:`SMWC_NWP_LO];

  // ================================================================
  // Code checks: only the pairwise distant codes are accepted
  always @* begin
    case (new_mode)
      `SMWC_WM_AUTO, `SMWC_WM_TIMEOUT, `SMWC_WM_WINDOW: begin
        mode_ok = 1'b1;
      end
      default: begin
        mode_ok = 1'b0;
      end
    endcase
    case (new_period)
      `SMWC_NWP_8, `SMWC_NWP_16, `SMWC_NWP_32, `SMWC_NWP_64,
      `SMWC_NWP_128, `SMWC_NWP_256, `SMWC_NWP_1024,
      `SMWC_NWP_4096: begin
        period_ok = 1'b1;
      end
      default: begin
        period_ok = 1'b0;
      end
    endcase
    wd_write = wr_i && (addr_i == `SMWC_OFS_WDCTL);
    trig_valid = wd_write && mode_ok && period_ok;
    // Same-mode writes in Normal are plain triggers, not violations
    ill_wmc = trig_valid && in_normal &&
      (new_mode != supervisor_mode_field_reg);
  end

  // ================================================================
  // Period lookup in clock cycles, from the live period field
  // Fixed counts: no prescaler, so a period change applies at once
  always @* begin
    case (supervisor_period_field_reg)
      `SMWC_NWP_8: period_cycles = `SMWC_CYC_8;
      `SMWC_NWP_16: period_cycles = `SMWC_CYC_16;
      `SMWC_NWP_32: period_cycles = `SMWC_CYC_32;
      `SMWC_NWP_64: period_cycles = `SMWC_CYC_64;
      `SMWC_NWP_256: period_cycles = `SMWC_CYC_256;
      `SMWC_NWP_1024: period_cycles = `SMWC_CYC_1024;
      `SMWC_NWP_4096: period_cycles = `SMWC_CYC_4096;
      default: period_cycles = `SMWC_CYC_128;
    endcase
  end

  // ================================================================
  // Behaviour selection from chip mode and configuration
  always @* begin
    wd_state = WS_OFF;
    if (in_forced || forced_normal_config_bit_i) begin
      wd_state = WS_OFF;
    end else if (supervisor_mode_field_reg == `SMWC_WM_AUTO) begin
      // Development bit keeps autonomous mode silent everywhere
      if (!software_dev_config_bit_i &&
          (in_normal || (in_standby && wake_pending_i))) begin
        wd_state = WS_TIMEOUT;
      end
    end else if (in_normal &&
                 supervisor_mode_field_reg == `SMWC_WM_WINDOW) begin
      wd_state = WS_WINDOW;
    end else if (in_normal || in_standby || in_sleep) begin
      // Window code outside Normal also lands here as timeout
      wd_state = WS_TIMEOUT;
    end
  end

  // Overflow on the last count of the period; never while off
  always @* begin
    overflow = (wd_state != WS_OFF) &&
      (wd_cnt_reg >= period_cycles - 30'h00000001);
  end

  // ================================================================
  // Configuration and status registers
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      supervisor_mode_field_reg <= `SMWC_WM_TIMEOUT;
      supervisor_period_field_reg <= `SMWC_NWP_128;
      chip_mode_field_o <= `SMWC_MC_STANDBY;
      first_normal_entry_flag_reg <= 1'b1;
      reset_cause_field_reg <= `SMWC_RC_POWERON;
      strap_done_reg <= 1'b0;
      spi_fail_o <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
      // Dev bit is sampled once after release, never in the reset
      // A control write on that first edge loses to the strap
      if (!strap_done_reg && software_dev_config_bit_i) begin
        supervisor_mode_field_reg <= `SMWC_WM_AUTO;
      end else if (trig_valid && !ill_wmc) begin
        supervisor_mode_field_reg <= new_mode;
        supervisor_period_field_reg <= new_period;
      end
      spi_fail_o <= wd_write && !(mode_ok && period_ok) &&
        spi_fail_en_i;
      if (wr_i && addr_i == `SMWC_OFS_MODE) begin
        case (wdata_i[2:0])
          `SMWC_MC_SLEEP, `SMWC_MC_STANDBY, `SMWC_MC_NORMAL: begin
            chip_mode_field_o <= wdata_i[2:0];
          end
          default: begin
            chip_mode_field_o <= chip_mode_field_o;
          end
        endcase
      end
      if (in_normal) begin
        first_normal_entry_flag_reg <= 1'b0;
      end
      // Own causes win over the sequencer's on the same edge
      if (ill_wmc) begin
        reset_cause_field_reg <= `SMWC_RC_ILL_WMC;
      end else if (wd_state == WS_WINDOW && trig_valid &&
                   wd_cnt_reg < (period_cycles >> 1)) begin
        reset_cause_field_reg <= `SMWC_RC_WD_EARLY;
      end else if (overflow && wd_state == WS_WINDOW) begin
        reset_cause_field_reg <= `SMWC_RC_WD_OVF;
      end else if (overflow && supervisor_failure_flag_o &&
                   !in_sleep) begin
        reset_cause_field_reg <= `SMWC_RC_WD_OVF;
      end else if (overflow && in_sleep) begin
        reset_cause_field_reg <= `SMWC_RC_WD_SLEEP;
      end else if (ext_reset_i) begin
        // Sequencer supplies codes for power, pin, wake, overtemp
        reset_cause_field_reg <= ext_reset_cause_i;
      end
    end
  end

  // ================================================================
  // Watchdog timer, failure flag and reset/wake requests
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wd_cnt_reg <= 30'h00000000;
      supervisor_failure_flag_o <= 1'b0;
      wd_reset_req_o <= 1'b0;
      wd_wake_o <= 1'b0;
      wd_phase_o <= 2'h0;
    end else begin
      wd_reset_req_o <= 1'b0;
      wd_wake_o <= 1'b0;
      // Every trigger starts a fresh period, early ones included
      if (wd_state == WS_OFF || trig_valid || overflow) begin
        wd_cnt_reg <= 30'h00000000;
      end else begin
        wd_cnt_reg <= wd_cnt_reg + 30'h00000001;
      end
      if (ill_wmc) begin
        wd_reset_req_o <= 1'b1;
      end else if (wd_state == WS_WINDOW) begin
        if ((trig_valid && wd_cnt_reg < (period_cycles >> 1)) ||
            overflow) begin
          wd_reset_req_o <= 1'b1;
        end
      end else if (wd_state == WS_TIMEOUT && overflow) begin
        if (in_sleep) begin
          wd_wake_o <= 1'b1;
        end else if (supervisor_failure_flag_o) begin
          wd_reset_req_o <= 1'b1;
        end
      end
      // Set wins over a clear on the same edge
      if (wd_state == WS_TIMEOUT && overflow) begin
        supervisor_failure_flag_o <= 1'b1;
      end else if (wdf_clear_i) begin
        supervisor_failure_flag_o <= 1'b0;
      end
      if (wd_state == WS_OFF) begin
        wd_phase_o <= 2'h0;
      end else if (wd_cnt_reg < (period_cycles >> 1)) begin
        wd_phase_o <= 2'h1;
      end else begin
        wd_phase_o <= 2'h2;
      end
    end
  end

  // ================================================================
  // Register read port, registered one cycle after rd_i
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `SMWC_OFS_WDCTL: rdata_o <= {supervisor_mode_field_reg, 1'b0,
          supervisor_period_field_reg};
        `SMWC_OFS_MODE: rdata_o <= {5'h00, chip_mode_field_o};
        `SMWC_OFS_MSTAT: rdata_o <= {1'b0, temp_warning_i,
          first_normal_entry_flag_reg,
          reset_cause_field_reg};
        // Unmapped addresses read as zero
        default: rdata_o <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- include/smwc_defines.vh ----
// Register offsets, field codes, reset values and timing counts for smwc
`ifndef SMWC_DEFINES_VH
`define SMWC_DEFINES_VH
// ==================================================================
// Register offsets
`define SMWC_OFS_WDCTL 7'h00
`define SMWC_OFS_MODE 7'h01
`define SMWC_OFS_MSTAT 7'h03
// ==================================================================
// Chip mode field codes
`define SMWC_MC_SLEEP 3'h1
`define SMWC_MC_STANDBY 3'h4
`define SMWC_MC_NORMAL 3'h7
// ==================================================================
// Supervisor mode field codes
`define SMWC_WM_AUTO 3'h1
`define SMWC_WM_TIMEOUT 3'h2
`define SMWC_WM_WINDOW 3'h4
// ==================================================================
// Supervisor period field codes
`define SMWC_NWP_8 4'h8
`define SMWC_NWP_16 4'h1
`define SMWC_NWP_32 4'h2
`define SMWC_NWP_64 4'hb
`define SMWC_NWP_128 4'h4
`define SMWC_NWP_256 4'hd
`define SMWC_NWP_1024 4'he
`define SMWC_NWP_4096 4'h7
// ==================================================================
// Field positions
`define SMWC_WM_HI 7
`define SMWC_WM_LO 5
`define SMWC_NWP_HI 3
`define SMWC_NWP_LO 0
`define SMWC_TW_BIT 6
`define SMWC_NE_BIT 5
// ==================================================================
// Reset cause codes
`define SMWC_RC_POWERON 5'h00
`define SMWC_RC_BUSWAKE 5'h01
`define SMWC_RC_LOCWAKE 5'h04
`define SMWC_RC_WD_SLEEP 5'h0c
`define SMWC_RC_DIAGWAKE 5'h0d
`define SMWC_RC_WD_EARLY 5'h0e
`define SMWC_RC_WD_OVF 5'h0f
`define SMWC_RC_ILL_WMC 5'h10
`define SMWC_RC_EXT_PIN 5'h11
`define SMWC_RC_OVERTEMP 5'h12
`define SMWC_RC_UNDERV 5'h13
`define SMWC_RC_ILL_SLEEP 5'h14
`define SMWC_RC_FRAMEERR 5'h16
// ==================================================================
// Timing: period lengths in 5 ns clock cycles (ms times 200000)
`define SMWC_CYC_8 30'h0186a00
`define SMWC_CYC_16 30'h030d400
`define SMWC_CYC_32 30'h061a800
`define SMWC_CYC_64 30'h0c35000
`define SMWC_CYC_128 30'h186a000
`define SMWC_CYC_256 30'h30d4000
`define SMWC_CYC_1024 30'hc350000
`define SMWC_CYC_4096 30'h30d40000
`endif

// ---- tb/smwc_monitor.sv ----
// Checker: port-level timing rules of the mode and supervisor block
`timescale 1ns/1ps
`default_nettype none
module smwc_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic spi_fail_o,
  input wire logic spi_fail_en_i,
  input wire logic [7:0] chip_state_i,
  input wire logic temp_warning_i,
  input wire logic [2:0] chip_mode_field_o,
  input wire logic wd_reset_req_o,
  input wire logic wd_wake_o,
  input wire logic [1:0] wd_phase_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ====================================================
  // Register side
  sequence s_mode_wr(logic ok);
    wr_i && addr_i == 7'h01 && ok;
  endsequence
  a_mode_take: assert property (
    s_mode_wr(wdata_i[2:0] inside {3'h1, 3'h4, 3'h7})
    |=> chip_mode_field_o == $past(wdata_i[2:0]))
    else $error("mode field missed a valid code");
  a_mode_keep: assert property (
    s_mode_wr(!(wdata_i[2:0] inside {3'h1, 3'h4, 3'h7}))
    |=> $stable(chip_mode_field_o))
    else $error("mode field took an invalid code");
  a_fail_cause: assert property (
    $rose(spi_fail_o) |-> $past(wr_i && addr_i == 7'h00 && spi_fail_en_i))
    else $error("failure pulse without an enabled control write");
  a_temp_read: assert property (
    rd_i && addr_i == 7'h03 |=> rdata_o[6] == $past(temp_warning_i))
    else $error("warning bit differs from the level");
  // ====================================================
  // Supervisor state; two-cycle hold allows for registered phase
  sequence s_held(logic c);
    c ##1 c;
  endsequence
  a_forced_off: assert property (
    s_held(chip_state_i[3]) |-> wd_phase_o == 2'b00)
    else $error("supervisor running in forced normal");
  a_other_off: assert property (
    s_held(chip_state_i == 8'h00) |-> wd_phase_o == 2'b00)
    else $error("supervisor running in an off state");
  a_reset_pulse: assert property (
    wd_reset_req_o |=> !wd_reset_req_o)
    else $error("reset request longer than one cycle");
  a_wake_sleep: assert property (
    wd_wake_o |-> $past(chip_state_i[2]))
    else $error("wake pulse outside sleep");
endmodule
bind smwc_top smwc_monitor u_mon (.clk_i, .nrst_i, .wr_i, .rd_i, .addr_i,
  .wdata_i, .rdata_o, .spi_fail_o, .spi_fail_en_i, .chip_state_i,
  .temp_warning_i, .chip_mode_field_o, .wd_reset_req_o, .wd_wake_o,
  .wd_phase_o);
`default_nettype wire

// ---- tb/smwc_host.sv ----
// Host model: register writes and reads on the strobe bus
`timescale 1ns/1ps
`default_nettype none
module smwc_host (
  input wire logic clk_i,
  output logic wr_o,
  output logic rd_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  // ====================================================
  // Bus cycles; data inverted after use so stale values never match
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 7'h7f;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = v;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~v;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    v = rdata_i;
  endtask
endmodule
`default_nettype wire

// ---- tb/smwc_tb_top.sv ----
// Bench top: drives the mode and supervisor block and checks its ports
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module smwc_tb_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wr_i, rd_i, spi_fail_en_i, wake_pending_i, temp_warning_i;
  logic forced_normal_config_bit_i, software_dev_config_bit_i;
  logic ext_reset_i, wdf_clear_i, spi_fail_o, wd_reset_req_o, wd_wake_o;
  logic supervisor_failure_flag_o;
  logic [6:0] addr_i;
  logic [7:0] wdata_i, rdata_o, chip_state_i, d, ctl;
  logic [4:0] ext_reset_cause_i;
  logic [2:0] chip_mode_field_o;
  logic [1:0] wd_phase_o;
  int n_fail = 0, check_count = 0, n_sf = 0, n_rq = 0, cyc = 0, tn = 0;
  int n_wk = 0;
  int x_sf, x_rq;
  logic [3:0] per [8] = '{4'h8, 4'h1, 4'h2, 4'hb, 4'h4, 4'hd, 4'he, 4'h7};
  logic [2:0] mc [3] = '{3'h1, 3'h7, 3'h4};
  logic [4:0] rc [9] = '{5'h00, 5'h11, 5'h13, 5'h01, 5'h04, 5'h0d, 5'h12,
    5'h14, 5'h16};
  smwc_top dut (.clk_i, .nrst_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o,
    .spi_fail_o, .spi_fail_en_i, .chip_state_i, .wake_pending_i,
    .forced_normal_config_bit_i, .software_dev_config_bit_i,
    .temp_warning_i, .ext_reset_cause_i, .ext_reset_i, .wdf_clear_i,
    .chip_mode_field_o, .wd_reset_req_o, .wd_wake_o,
    .supervisor_failure_flag_o, .wd_phase_o);
  smwc_host host (.clk_i, .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i),
    .wdata_o(wdata_i), .rdata_i(rdata_o));
  always #2.5 clk_i = ~clk_i;
  // Pulse counters; the hang guard sits far beyond the few hundred needed
  always @(posedge clk_i) begin
    n_sf += spi_fail_o;
    n_rq += wd_reset_req_o;
    n_wk += wd_wake_o;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  // ====================================================
  // Helpers
  function automatic bit vld(logic [7:0] w);
    return w[7:5] inside {3'h1, 3'h2, 3'h4} && w[3:0] inside {per};
  endfunction
  task automatic ph(input logic [7:0] s, input logic [1:0] e);
    chip_state_i = s;
    repeat (3) @(negedge clk_i);
    `CHK(wd_phase_o, e)
  endtask
  task automatic tend;
    tn++;
    $display("test %0d done", tn);
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ====================================================
  // Main sequence
  initial begin
    void'($urandom(31));
    {spi_fail_en_i, wake_pending_i, forced_normal_config_bit_i} = 3'h0;
    {software_dev_config_bit_i, ext_reset_i, wdf_clear_i} = 3'h0;
    ext_reset_cause_i = 5'h00;
    chip_state_i = 8'h02;
    temp_warning_i = 1'($urandom);
    repeat (4) @(negedge clk_i);
    nrst_i = 1'b1;
    @(negedge clk_i);
    host.rd(7'h03, d);
    `CHK(d, {1'b0, temp_warning_i, 1'b1, 5'h00})
    host.rd(7'h00, d);
    `CHK(d, 8'h44)
    host.rd(7'h02, d);
    `CHK(d, 8'h00)
    tend();
    // Each code, then a one-bit corruption of it that must be ignored
    foreach (mc[i]) begin
      host.wr(7'h01, {5'h00, mc[i]});
      host.wr(7'h01, {5'h00, mc[i] ^ 3'h1});
      `CHK(chip_mode_field_o, mc[i])
      host.rd(7'h01, d);
      `CHK(d, {5'h00, mc[i]})
    end
    tend();
    ctl = 8'h44;
    x_sf = n_sf;
    for (int i = 0; i < 16; i++) begin
      d = (i == 0) ? 8'h64 : (i == 1) ? 8'h49 : 8'($urandom);
      spi_fail_en_i = (i < 2) ? 1'b1 : 1'($urandom);
      x_sf += (!vld(d) && spi_fail_en_i);
      if (vld(d))
        ctl = {d[7:5], 1'b0, d[3:0]};
      host.wr(7'h00, d);
      host.rd(7'h00, d);
      `CHK(d, ctl)
      `CHK(n_sf, x_sf)
    end
    foreach (per[i]) begin
      host.wr(7'h00, {4'h4, per[i]});
      host.rd(7'h00, d);
      `CHK(d, {4'h4, per[i]})
    end
    tend();
    host.wr(7'h00, 8'h48);
    ph(8'h02, 2'b01);
    ph(8'h04, 2'b01);
    ph(8'h08, 2'b00);
    ph(8'h00, 2'b00);
    forced_normal_config_bit_i = 1'b1;
    ph(8'h02, 2'b00);
    forced_normal_config_bit_i = 1'b0;
    host.wr(7'h00, 8'h28);
    ph(8'h02, 2'b00);
    wake_pending_i = 1'b1;
    ph(8'h02, 2'b01);
    ph(8'h04, 2'b00);
    ph(8'h01, 2'b01);
    tend();
    // Window chosen in standby, armed only on entry to normal
    ph(8'h02, 2'b01);
    host.wr(7'h00, 8'h88);
    ph(8'h02, 2'b01);
    ph(8'h01, 2'b01);
    x_rq = n_rq;
    host.wr(7'h00, 8'h88);
    host.rd(7'h03, d);
    `CHK(d, {1'b0, temp_warning_i, 1'b0, 5'h0e})
    `CHK(n_rq, x_rq + 1)
    host.wr(7'h00, 8'h48);
    host.rd(7'h03, d);
    `CHK(d[4:0], 5'h10)
    `CHK(n_rq, x_rq + 2)
    host.rd(7'h00, d);
    `CHK(d, 8'h88)
    tend();
    foreach (rc[i]) begin
      temp_warning_i = 1'($urandom);
      ext_reset_cause_i = rc[i];
      ext_reset_i = 1'b1;
      @(negedge clk_i);
      ext_reset_i = 1'b0;
      host.rd(7'h03, d);
      `CHK(d, {1'b0, temp_warning_i, 1'b0, rc[i]})
    end
    wdf_clear_i = 1'b1;
    @(negedge clk_i);
    wdf_clear_i = 1'b0;
    `CHK(supervisor_failure_flag_o, 1'b0)
    // No period ever runs out here, so no wake pulse may appear
    `CHK(n_wk, 0)
    tend();
    // Second reset with the development bit set picks autonomous mode
    software_dev_config_bit_i = 1'b1;
    nrst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    @(negedge clk_i);
    host.rd(7'h00, d);
    `CHK(d, 8'h24)
    ph(8'h02, 2'b00);
    tend();
    close_out();
  end
endmodule
`default_nettype wire
